/* hw/rsc_pkg.sv */
// constants, types and field layouts of the redundancy switch controller
package rsc_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int BAUD = 9600;
    localparam int BIT_CYC = CLK_HZ / BAUD;
    localparam logic [11:0] BIT_CNT = 12'(BIT_CYC - 1);
    localparam logic [11:0] HALF_CNT = 12'(BIT_CYC / 2 - 1);
    localparam int PF_N = 4;
    // register byte offsets
    localparam logic [4:0] OFS_STATUS = 5'h00;
    localparam logic [4:0] OFS_CFG = 5'h04;
    localparam logic [4:0] OFS_NOM_ONE = 5'h08;
    localparam logic [4:0] OFS_NOM_TWO = 5'h0c;
    localparam logic [4:0] OFS_NOM_BACKUP = 5'h10;
    // cfg fields
    localparam int CFG_RS485 = 0;
    localparam int CFG_LATCH = 1;
    localparam int CFG_ADDR_LO = 8;
    // status fields
    localparam int ST_POS_LO = 0;
    localparam int ST_MODE_LO = 4;
    localparam int ST_PRIO_LO = 8;
    localparam int ST_ALARM_LO = 12;
    localparam int ST_PWR = 16;
    localparam int ST_LATCH = 17;
    localparam logic [11:0] NOM_RST = 12'h000;
    localparam logic [1:0] PRIO_RST = 2'h1;
    // switch positions
    localparam logic [1:0] POS_NONE = 2'h0;
    localparam logic [1:0] POS_ONE = 2'h1;
    localparam logic [1:0] POS_TWO = 2'h2;
    // framing characters
    localparam logic [7:0] CH_OPEN = 8'h7b;
    localparam logic [7:0] CH_CLOSE = 8'h7d;
    localparam logic [7:0] CH_ACK = 8'h3e;
    localparam logic [7:0] CH_CLS_CMD = 8'h43;
    localparam logic [7:0] CH_CMD_POS = 8'h41;
    localparam logic [7:0] CH_CMD_PRIO = 8'h50;
    localparam logic [7:0] CH_CMD_RESET = 8'h42;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [9:0] TX_IDLE_SH = 10'h3ff;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rsc_rx_t;
    typedef enum logic [2:0] {P_IDLE, P_ADDR1, P_ADDR2, P_CLASS, P_CODE, P_DATA} rsc_prs_t;

    typedef struct packed {
        logic [11:0] one;
        logic [11:0] two;
        logic [11:0] backup;
    } rsc_amps_t;

    typedef struct packed {
        logic manual;
        logic up;
        logic down;
        logic reset;
    } rsc_panel_t;

    typedef struct packed {
        logic manual;
        logic remote;
        logic auto_mode;
        logic [2:0] alarm;
        logic power;
    } rsc_leds_t;
endpackage : rsc_pkg

/* hw/rsc_ctrl.sv */
// redundancy switch controller: mode arbitration, alarms, serial command parser, register slave
//
// Implementation choices: the Avalon-MM register port and the register offsets.
module rsc_ctrl
    import rsc_pkg::*;
// bit-time counts default to 9600 baud; a shorter bit time keeps link tests quick
#(
    parameter logic [11:0] BIT_LAST = BIT_CNT,
    parameter logic [11:0] BIT_HALF = HALF_CNT
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic uart_rx,
    output logic uart_tx,
    input wire rsc_panel_t panel,
    input wire rsc_amps_t amp_current,
    input wire logic [PF_N-1:0] pwr_fail,
    output logic [1:0] switch_pos,
    output rsc_leds_t leds,
    output logic alarm_relay
);
    typedef struct packed {
        logic rx_m;
        logic rx_s;
        rsc_panel_t pan_m;
        rsc_panel_t pan_s;
        rsc_panel_t pan_q;
        logic [PF_N-1:0] pf_m;
        logic [PF_N-1:0] pf_s;
        rsc_rx_t rxst;
        logic [11:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic tx_busy;
        logic [11:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        logic ack_pend;
        rsc_prs_t pst;
        logic [6:0] addr;
        logic [7:0] cls;
        logic [7:0] code;
        logic [7:0] dat;
        logic [1:0] ndat;
        logic remote;
        logic [1:0] rpos;
        logic [1:0] mpos;
        logic [1:0] prio;
        logic latch2;
        logic [1:0] pos;
        logic [2:0] alarm;
        logic pwr;
        logic [11:0] nom_one;
        logic [11:0] nom_two;
        logic [11:0] nom_backup;
        logic cfg_rs485;
        logic cfg_latch;
        logic [4:0] cfg_addr;
        logic ack;
        logic [31:0] rdata;
    } rsc_state_t;

    rsc_state_t s;
    rsc_state_t next_s;

    // more than 15 percent off: |meas-nom|*100 > nom*15, scaled down by 5
    function automatic logic cur_alarm(input logic [11:0] meas, input logic [11:0] nom);
        logic [11:0] diff;
        diff = (meas > nom) ? meas - nom : nom - meas;
        return ({6'h00, diff} * 18'h00014) > ({6'h00, nom} * 18'h00003);
    endfunction : cur_alarm

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : be_merge

    function automatic logic is_digit(input logic [7:0] c);
        return c >= CH_ZERO && c <= 8'h39;
    endfunction : is_digit

    logic bus_req;
    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~s.ack;
    assign avs_readdata = s.rdata;
    assign uart_tx = s.tx_sh[0];
    assign switch_pos = s.pos;
    assign alarm_relay = s.pwr;

    always_comb begin
        logic rx_valid;
        logic manual;
        logic up_p;
        logic down_p;
        logic reset_p;
        logic do_reset;
        logic frame_ok;
        logic [1:0] auto_pos;
        logic [6:0] digit;
        logic [31:0] wd;
        rx_valid = 1'b0;
        do_reset = 1'b0;
        frame_ok = 1'b0;
        wd = 32'h0000_0000;
        next_s = s;

        // two-flop synchronisers for pins
        next_s.rx_m = uart_rx;
        next_s.rx_s = s.rx_m;
        next_s.pan_m = panel;
        next_s.pan_s = s.pan_m;
        next_s.pan_q = s.pan_s;
        next_s.pf_m = pwr_fail;
        next_s.pf_s = s.pf_m;
        manual = s.pan_s.manual;
        up_p = s.pan_s.up & ~s.pan_q.up;
        down_p = s.pan_s.down & ~s.pan_q.down;
        reset_p = s.pan_s.reset & ~s.pan_q.reset;
        digit = 7'(s.rx_sh - CH_ZERO);

        // receiver, sampled mid-bit
        case (s.rxst)
            RX_IDLE: begin
                if (!s.rx_s) begin
                    next_s.rxst = RX_START;
                    next_s.rx_cnt = 12'h000;
                end
            end
            RX_START: begin
                next_s.rx_cnt = s.rx_cnt + 12'h001;
                if (s.rx_cnt == BIT_HALF) begin
                    next_s.rx_cnt = 12'h000;
                    next_s.rx_bit = 3'h0;
                    next_s.rxst = s.rx_s ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                next_s.rx_cnt = s.rx_cnt + 12'h001;
                if (s.rx_cnt == BIT_LAST) begin
                    next_s.rx_cnt = 12'h000;
                    next_s.rx_sh = {s.rx_s, s.rx_sh[7:1]};
                    next_s.rx_bit = s.rx_bit + 3'h1;
                    if (s.rx_bit == 3'h7) begin
                        next_s.rxst = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                next_s.rx_cnt = s.rx_cnt + 12'h001;
                if (s.rx_cnt == BIT_LAST) begin
                    // a byte with a broken stop bit is dropped
                    rx_valid = s.rx_s;
                    next_s.rxst = RX_IDLE;
                end
            end
            default: next_s.rxst = RX_IDLE;
        endcase

        // frame parser
        if (rx_valid) begin
            if (s.rx_sh == CH_OPEN) begin
                next_s.pst = s.cfg_rs485 ? P_ADDR1 : P_CLASS;
                next_s.ndat = 2'h0;
            end else begin
                case (s.pst)
                    P_IDLE: next_s.pst = P_IDLE;
                    P_ADDR1: begin
                        next_s.addr = 7'(digit * 7'd10);
                        next_s.pst = is_digit(s.rx_sh) ? P_ADDR2 : P_IDLE;
                    end
                    P_ADDR2: begin
                        next_s.addr = s.addr + digit;
                        next_s.pst = is_digit(s.rx_sh) ? P_CLASS : P_IDLE;
                    end
                    P_CLASS: begin
                        next_s.cls = s.rx_sh;
                        next_s.pst = P_CODE;
                    end
                    P_CODE: begin
                        next_s.code = s.rx_sh;
                        next_s.pst = (s.rx_sh == CH_CLOSE) ? P_IDLE : P_DATA;
                    end
                    P_DATA: begin
                        if (s.rx_sh == CH_CLOSE) begin
                            next_s.pst = P_IDLE;
                            frame_ok = s.cls == CH_CLS_CMD &&
                                       (!s.cfg_rs485 || s.addr == {2'h0, s.cfg_addr});
                        end else begin
                            if (s.ndat == 2'h0) begin
                                next_s.dat = s.rx_sh;
                            end
                            if (s.ndat != 2'h3) begin
                                next_s.ndat = s.ndat + 2'h1;
                            end
                        end
                    end
                    default: next_s.pst = P_IDLE;
                endcase
            end
        end

        // command execution; anything else is dropped silently
        if (frame_ok) begin
            case (s.code)
                CH_CMD_POS: begin
                    if (s.ndat == 2'h1 && s.dat >= CH_ZERO && s.dat <= 8'h32) begin
                        next_s.ack_pend = 1'b1;
                        if (!manual) begin
                            next_s.remote = 1'b1;
                            next_s.rpos = s.dat[1:0];
                        end
                    end
                end
                CH_CMD_PRIO: begin
                    if (s.ndat == 2'h1 && (s.dat == 8'h31 || s.dat == 8'h32)) begin
                        next_s.prio = s.dat[1:0];
                        next_s.ack_pend = 1'b1;
                    end
                end
                CH_CMD_RESET: begin
                    if (s.ndat == 2'h0) begin
                        do_reset = 1'b1;
                        next_s.ack_pend = 1'b1;
                    end
                end
                default: next_s.ack_pend = s.ack_pend;
            endcase
        end

        // alarms
        next_s.alarm[0] = cur_alarm(amp_current.one, s.nom_one);
        next_s.alarm[1] = cur_alarm(amp_current.two, s.nom_two);
        next_s.alarm[2] = cur_alarm(amp_current.backup, s.nom_backup);
        next_s.pwr = |s.pf_s;

        // automatic selection
        if (s.alarm[2]) begin
            auto_pos = POS_NONE;
        end else if (s.alarm[0] && s.alarm[1]) begin
            auto_pos = (s.prio == POS_TWO) ? POS_TWO : POS_ONE;
        end else if (s.alarm[0]) begin
            auto_pos = POS_ONE;
        end else if (s.alarm[1]) begin
            auto_pos = POS_TWO;
        end else begin
            auto_pos = POS_NONE;
        end
        if (s.latch2 && !s.alarm[2]) begin
            auto_pos = POS_TWO;
        end

        // panel reset behaves like the reset command
        if (reset_p || do_reset) begin
            next_s.remote = 1'b0;
            if (!s.alarm[0]) begin
                next_s.latch2 = 1'b0;
            end
        end

        // manual stepping: none -> one -> two -> none
        if (manual) begin
            if (!s.pan_q.manual) begin
                next_s.mpos = s.pos;
            end else if (up_p) begin
                next_s.mpos = (s.mpos == POS_TWO) ? POS_NONE : s.mpos + 2'h1;
            end else if (down_p) begin
                next_s.mpos = (s.mpos == POS_NONE) ? POS_TWO : s.mpos - 2'h1;
            end
        end

        if (manual) begin
            // hold the switch in the cycle that loads mpos, so no stale position shows
            next_s.pos = s.pan_q.manual ? s.mpos : s.pos;
        end else if (s.remote) begin
            next_s.pos = s.rpos;
        end else begin
            next_s.pos = auto_pos;
            if (s.cfg_latch && auto_pos == POS_TWO && !(reset_p || do_reset)) begin
                next_s.latch2 = 1'b1;
            end
        end

        // transmitter: '>' once per accepted command, also for a position command ignored in manual mode
        if (!s.tx_busy) begin
            if (s.ack_pend) begin
                next_s.ack_pend = frame_ok;
                next_s.tx_busy = 1'b1;
                next_s.tx_sh = {1'b1, CH_ACK, 1'b0};
                next_s.tx_cnt = 12'h000;
                next_s.tx_bit = 4'h0;
            end
        end else begin
            next_s.tx_cnt = s.tx_cnt + 12'h001;
            if (s.tx_cnt == BIT_LAST) begin
                next_s.tx_cnt = 12'h000;
                next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
                next_s.tx_bit = s.tx_bit + 4'h1;
                if (s.tx_bit == 4'h9) begin
                    next_s.tx_busy = 1'b0;
                end
            end
        end

        // avalon slave: one wait cycle, then the access completes
        next_s.ack = bus_req & ~s.ack;
        if (bus_req && !s.ack) begin
            case (avs_address)
                OFS_STATUS: begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rdata[ST_POS_LO +: 2] = s.pos;
                    next_s.rdata[ST_MODE_LO +: 3] = {~manual & ~s.remote, s.remote & ~manual, manual};
                    next_s.rdata[ST_PRIO_LO +: 2] = s.prio;
                    next_s.rdata[ST_ALARM_LO +: 3] = s.alarm;
                    next_s.rdata[ST_PWR] = s.pwr;
                    next_s.rdata[ST_LATCH] = s.latch2;
                end
                OFS_CFG: begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rdata[CFG_RS485] = s.cfg_rs485;
                    next_s.rdata[CFG_LATCH] = s.cfg_latch;
                    next_s.rdata[CFG_ADDR_LO +: 5] = s.cfg_addr;
                end
                OFS_NOM_ONE: next_s.rdata = {20'h00000, s.nom_one};
                OFS_NOM_TWO: next_s.rdata = {20'h00000, s.nom_two};
                OFS_NOM_BACKUP: next_s.rdata = {20'h00000, s.nom_backup};
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
        if (avs_write && s.ack) begin
            case (avs_address)
                OFS_CFG: begin
                    wd = be_merge({19'h00000, s.cfg_addr, 6'h00, s.cfg_latch, s.cfg_rs485},
                                  avs_writedata, avs_byteenable);
                    next_s.cfg_rs485 = wd[CFG_RS485];
                    next_s.cfg_latch = wd[CFG_LATCH];
                    next_s.cfg_addr = wd[CFG_ADDR_LO +: 5];
                end
                OFS_NOM_ONE: begin
                    wd = be_merge({20'h00000, s.nom_one}, avs_writedata, avs_byteenable);
                    next_s.nom_one = wd[11:0];
                end
                OFS_NOM_TWO: begin
                    wd = be_merge({20'h00000, s.nom_two}, avs_writedata, avs_byteenable);
                    next_s.nom_two = wd[11:0];
                end
                OFS_NOM_BACKUP: begin
                    wd = be_merge({20'h00000, s.nom_backup}, avs_writedata, avs_byteenable);
                    next_s.nom_backup = wd[11:0];
                end
                default: wd = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s <= '0;
            s.rx_m <= 1'b1;
            s.rx_s <= 1'b1;
            s.tx_sh <= TX_IDLE_SH;
            s.prio <= PRIO_RST;
            s.nom_one <= NOM_RST;
            s.nom_two <= NOM_RST;
            s.nom_backup <= NOM_RST;
        end else begin
            s <= next_s;
        end
    end

    // indicators
    assign leds.manual = s.pan_s.manual;
    assign leds.remote = s.remote & ~s.pan_s.manual;
    assign leds.auto_mode = ~s.remote & ~s.pan_s.manual;
    assign leds.alarm = s.alarm;
    assign leds.power = s.pwr;
endmodule : rsc_ctrl

/* bench/rsc_ctrl_sva.sv */
// concurrent checks on the controller ports
module rsc_ctrl_sva
    import rsc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic uart_rx,
    input wire logic uart_tx,
    input wire rsc_panel_t panel,
    input wire rsc_amps_t amp_current,
    input wire logic [PF_N-1:0] pwr_fail,
    input wire logic [1:0] switch_pos,
    input wire rsc_leds_t leds,
    input wire logic alarm_relay
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait cycle");
    a_mode_onehot: assert property ($onehot({leds.manual, leds.remote, leds.auto_mode}))
        else $error("mode indicators not one-hot");
    a_relay_follows: assert property (alarm_relay == leds.power)
        else $error("alarm contact differs from power alarm");
    a_power_lit: assert property ((|pwr_fail) [*6] |-> leds.power)
        else $error("converter failure not shown");
    a_manual_on: assert property (panel.manual [*5] |-> leds.manual)
        else $error("manual mode not entered");
    a_manual_off: assert property ((!panel.manual) [*5] |-> !leds.manual)
        else $error("manual mode held without panel");
    a_tx_idle: assert property ($fell(srst) |-> uart_tx)
        else $error("serial output not idle after reset");
    a_start_bit: assert property ($fell(uart_tx) |=> !uart_tx [*8])
        else $error("start bit too short");
    a_auto_one: assert property ((leds.auto_mode && leds.alarm == 3'h1) [*4] |-> switch_pos == POS_ONE)
        else $error("faulted channel one not backed up");
    a_backup_bad: assert property ((leds.auto_mode && leds.alarm[2]) [*4] |-> switch_pos == POS_NONE)
        else $error("alarmed backup routed into path");
endmodule : rsc_ctrl_sva

bind rsc_ctrl rsc_ctrl_sva u_sva (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .uart_rx(uart_rx), .uart_tx(uart_tx),
    .panel(panel), .amp_current(amp_current), .pwr_fail(pwr_fail), .switch_pos(switch_pos), .leds(leds),
    .alarm_relay(alarm_relay));

/* bench/rsc_host.sv */
// remote host model: sends framed commands and receives replies on the serial link
module rsc_host
    import rsc_pkg::*;
#(
    parameter int BIT_DIV = BIT_CYC
) (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out,
    output logic [7:0] rx_byte,
    output logic rx_stb
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh;

    initial begin
        line_out = 1'b1;
        rx_byte = 8'h00;
        rx_stb = 1'b0;
    end

    // gap idles the line between characters, so a slow host is also exercised
    task automatic send_byte(input logic [7:0] b, input int gap);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        repeat (gap) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            line_out <= fr[i];
            repeat (BIT_DIV - 1) @(posedge clk);
        end
    endtask : send_byte

    // no address prefix: the link stays in point-to-point mode
    task automatic send_frame(input logic [7:0] cls, input logic [7:0] code, input logic [7:0] data,
                              input int n, input int gap);
        send_byte(CH_OPEN, gap);
        send_byte(cls, gap);
        send_byte(code, gap);
        if (n > 0) send_byte(data, gap);
        send_byte(CH_CLOSE, gap);
    endtask : send_frame

    always begin
        @(negedge line_in);
        repeat (BIT_DIV / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_DIV) @(posedge clk);
            sh[i] = line_in;
        end
        repeat (BIT_DIV) @(posedge clk);
        if (line_in === 1'b1) begin
            rx_byte <= sh;
            rx_stb <= 1'b1;
            @(posedge clk);
            rx_stb <= 1'b0;
        end
    end
endmodule : rsc_host

/* bench/rsc_ctrl_bench.sv */
// self-checking bench of the redundancy switch controller
module rsc_ctrl_bench
    import rsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [2:0] M_AUTO = 3'h4;
    localparam logic [2:0] M_REM = 3'h2;
    localparam logic [2:0] M_MAN = 3'h1;
    // short bit time: a 9600 baud frame would take far too many cycles
    localparam int BITS = 32;
    logic clk = 1'b0;
    logic srst, avs_read, avs_write, avs_waitrequest, uart_rx, uart_tx, alarm_relay, host_stb;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [7:0] host_byte;
    rsc_panel_t panel;
    rsc_amps_t amp_current;
    logic [PF_N-1:0] pwr_fail, pf;
    logic [1:0] switch_pos;
    rsc_leds_t leds;
    int miscompares = 0;
    int cmp_count = 0;
    logic [31:0] rd_q[$];
    logic [7:0] ack_q[$];
    logic [11:0] nom[3], cur[3];
    logic [2:0] alm_v;
    int pct[6][3] = '{'{100, 100, 100}, '{114, 100, 100}, '{120, 100, 100}, '{100, 84, 100},
                      '{120, 80, 100}, '{120, 100, 130}};

    always #20 clk = ~clk;

    rsc_ctrl #(.BIT_LAST(12'(BITS - 1)), .BIT_HALF(12'(BITS / 2 - 1)))
        u_rsc_ctrl (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .uart_rx(uart_rx), .uart_tx(uart_tx),
        .panel(panel), .amp_current(amp_current), .pwr_fail(pwr_fail), .switch_pos(switch_pos), .leds(leds),
        .alarm_relay(alarm_relay));
    rsc_host #(.BIT_DIV(BITS))
        u_rsc_host (.clk(clk), .line_in(uart_tx), .line_out(uart_rx), .rx_byte(host_byte), .rx_stb(host_stb));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task finish_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    function logic alarmed(input logic [11:0] m, input logic [11:0] n);
        int d;
        d = int'(m) - int'(n);
        if (d < 0) d = -d;
        return d * 20 > int'(n) * 3;
    endfunction : alarmed

    function logic [1:0] auto_pos(input logic [2:0] a, input logic [1:0] pr);
        if (a[2]) return POS_NONE;
        if (a[0] && a[1]) return (pr == 2'h1) ? POS_ONE : POS_TWO;
        if (a[0]) return POS_ONE;
        return a[1] ? POS_TWO : POS_NONE;
    endfunction : auto_pos

    function logic [31:0] st(input logic [1:0] pos, input logic [2:0] mode, input logic [1:0] pr, input logic pw);
        return {15'h0, pw, 1'b0, alm_v, 2'h0, pr, 1'b0, mode, 2'h0, pos};
    endfunction : st

    task bus(input logic [4:0] a, input logic wr, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task rd(input logic [4:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(a, 1'b0, 32'h0);
    endtask : rd

    task drive(input int p0, input int p1, input int p2);
        int p[3];
        p = '{p0, p1, p2};
        for (int i = 0; i < 3; i++) begin
            cur[i] = 12'(int'(nom[i]) * p[i] / 100);
            alm_v[i] = alarmed(cur[i], nom[i]);
        end
        amp_current <= '{cur[0], cur[1], cur[2]};
        repeat (8) @(posedge clk);
    endtask : drive

    task frame(input logic [7:0] cls, input logic [7:0] code, input logic [7:0] data, input int n, input bit acked);
        if (acked) ack_q.push_back(CH_ACK);
        u_rsc_host.send_frame(cls, code, data, n, int'($urandom % 3) * BITS);
        if (acked) begin
            for (int i = 0; i < 12 * BITS && ack_q.size() != 0; i++) @(posedge clk);
            check(32'(ack_q.size()), 32'h0);
            ack_q.delete();
        end else begin
            repeat (12 * BITS) @(posedge clk);
        end
    endtask : frame

    task press(input bit up);
        if (up) panel.up <= 1'b1;
        else panel.down <= 1'b1;
        repeat (5) @(posedge clk);
        panel.up <= 1'b0;
        panel.down <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : press

    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            if (rd_q.size() == 0) check(avs_readdata, 32'hx);
            else check(avs_readdata, rd_q.pop_front());
        end
    end

    always @(posedge host_stb) begin
        if (ack_q.size() == 0) check(32'(host_byte), 32'hffffffff);
        else check(32'(host_byte), 32'(ack_q.pop_front()));
    end

    initial begin
        #(40 * 40000);
        miscompares++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        srst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        panel = '0;
        amp_current = '0;
        pwr_fail = '0;
        alm_v = 3'h0;
        void'($urandom(95));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rd(OFS_STATUS, st(POS_NONE, M_AUTO, PRIO_RST, 1'b0));
        rd(OFS_CFG, 32'h0);
        rd(5'h14, 32'h0);
        $display("test reset finished");
        for (int i = 0; i < 3; i++) begin
            nom[i] = 12'(1000 + $urandom % 2000);
            bus(OFS_NOM_ONE + 5'(4 * i), 1'b1, {20'h0, nom[i]});
            rd(OFS_NOM_ONE + 5'(4 * i), {20'h0, nom[i]});
        end
        for (int k = 0; k < 6; k++) begin
            drive(pct[k][0], pct[k][1], pct[k][2]);
            rd(OFS_STATUS, st(auto_pos(alm_v, 2'h1), M_AUTO, 2'h1, 1'b0));
        end
        $display("test auto finished");
        frame(CH_CLS_CMD, CH_CMD_PRIO, 8'h32, 1, 1'b1);
        drive(120, 120, 100);
        rd(OFS_STATUS, st(POS_TWO, M_AUTO, 2'h2, 1'b0));
        for (int x = 2; x >= 0; x--) begin
            frame(CH_CLS_CMD, CH_CMD_POS, CH_ZERO + 8'(x), 1, 1'b1);
            rd(OFS_STATUS, st(2'(x), M_REM, 2'h2, 1'b0));
        end
        frame(8'h53, 8'h5a, 8'h00, 0, 1'b0);
        frame(CH_CLS_CMD, CH_CMD_RESET, 8'h00, 0, 1'b1);
        rd(OFS_STATUS, st(POS_TWO, M_AUTO, 2'h2, 1'b0));
        $display("test serial finished");
        pf = '0;
        pf[$urandom % PF_N] = 1'b1;
        pwr_fail <= pf;
        repeat (8) @(posedge clk);
        rd(OFS_STATUS, st(POS_TWO, M_AUTO, 2'h2, 1'b1));
        check(32'(alarm_relay), 32'h1);
        pwr_fail <= '0;
        $display("test power finished");
        panel.manual <= 1'b1;
        repeat (8) @(posedge clk);
        drive(100, 100, 100);
        rd(OFS_STATUS, st(POS_TWO, M_MAN, 2'h2, 1'b0));
        frame(CH_CLS_CMD, CH_CMD_POS, 8'h31, 1, 1'b1);
        rd(OFS_STATUS, st(POS_TWO, M_MAN, 2'h2, 1'b0));
        for (int k = 0; k < 3; k++) begin
            press(1'b1);
            rd(OFS_STATUS, st(2'(k), M_MAN, 2'h2, 1'b0));
        end
        press(1'b0);
        rd(OFS_STATUS, st(POS_ONE, M_MAN, 2'h2, 1'b0));
        panel.manual <= 1'b0;
        repeat (8) @(posedge clk);
        rd(OFS_STATUS, st(POS_NONE, M_AUTO, 2'h2, 1'b0));
        $display("test manual finished");
        finish_test();
    end
endmodule : rsc_ctrl_bench
